// [dv/sep_assertions.sv]
// Purpose: Protocol checks on the pin link between master and device.
// Assumes: All pins sampled on clk_sys; master makes the link clock.
// Notes: Device sync delay gives its outputs a few cycles of slack.
`timescale 1ns/1ns
module sep_assertions
	import sep_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic chip_sel,
	input wire logic link_clk,
	input wire logic serial_input,
	input wire logic program_enable_pin,
	input wire logic protect_enable_pin,
	input wire logic sout_o,
	input wire logic sout_oe,
	input wire logic sout
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	logic [4:0] low_cnt_q;
	logic [4:0] low_cnt_d;
	// Deselect length; full during reset so reset counts as deselect
	always_comb
	begin
		low_cnt_d = low_cnt_q;
		if (srst)
			low_cnt_d = 5'h1f;
		else if (chip_sel)
			low_cnt_d = 5'h00;
		else if (low_cnt_q != 5'h1f)
			low_cnt_d = low_cnt_q + 5'h01;
	end
	always_ff @(posedge clk_sys)
	begin
		low_cnt_q <= low_cnt_d;
	end
	property p_gap;
		$rose(chip_sel) |-> low_cnt_q >= 5'(DESELECT_CYC);
	endproperty
	a_gap: assert property (p_gap) else $error("deselect gap too short");
	property p_idle_clk;
		!chip_sel |-> !link_clk;
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("link clock moves while idle");
	property p_si_hold;
		link_clk && $past(link_clk) |-> $stable(serial_input);
	endproperty
	a_si_hold: assert property (p_si_hold) else $error("input bit moved while clock high");
	property p_clk_high;
		$rose(link_clk) |-> link_clk [*4] ##1 !link_clk;
	endproperty
	a_clk_high: assert property (p_clk_high) else $error("link clock high time wrong");
	property p_clk_low;
		$fell(link_clk) |-> !link_clk [*4];
	endproperty
	a_clk_low: assert property (p_clk_low) else $error("link clock low time short");
	property p_pe_hold;
		chip_sel && $past(chip_sel) |-> $stable(program_enable_pin);
	endproperty
	a_pe_hold: assert property (p_pe_hold) else $error("program enable moved in frame");
	property p_pre_hold;
		chip_sel && $past(chip_sel) |-> $stable(protect_enable_pin);
	endproperty
	a_pre_hold: assert property (p_pre_hold) else $error("protect enable moved in frame");
	property p_oe_off;
		!chip_sel [*6] |-> !sout_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
	property p_oe_sel;
		$rose(sout_oe) |-> $past(chip_sel, 2) && $past(chip_sel, 3);
	endproperty
	a_oe_sel: assert property (p_oe_sel) else $error("output drive without select");
	// Main traffic kinds seen at all
	c_drive: cover property ($rose(sout_oe));
	c_prot: cover property ($rose(chip_sel) && protect_enable_pin);
	c_poll: cover property (sout_oe && !sout_o && !link_clk);
endmodule

// [dv/tb.sv]
// Purpose: Self-checking bench joining master and device over the link.
// Assumes: Device timer shortened so programming cycles stay brief.
// Notes: Responses checked in order against a queue of notes.
`timescale 1ns/1ns
module tb import sep_pkg::*;;
	logic clk_sys, srst, req_valid, req_ready, req_prot, req_prog, req_poll, rsp_valid, busy;
	logic [1:0] req_op;
	logic [ADDR_W-1:0] req_addr;
	logic [DATA_W-1:0] req_data, rsp_data;
	logic [PTR_W-1:0] protect_ptr;
	logic [DATA_W:0] note_q[$];
	logic [DATA_W:0] nt;
	logic [ADDR_W-1:0] a[4];
	logic [DATA_W-1:0] d[4];
	int fail_count, num_checks, seed, i;
	sep_link_if link();
	sep_master u_sep_master (.clk_sys(clk_sys), .srst(srst), .link(link),
		.req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_prot(req_prot),
		.req_prog(req_prog), .req_poll(req_poll), .req_addr(req_addr), .req_data(req_data),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data));
	// Short timer keeps busy windows small but longer than a poll
	sep_device #(.PROG_CYC(50)) u_sep_device (.clk_sys(clk_sys), .srst(srst), .link(link),
		.busy(busy), .protect_ptr(protect_ptr));
	sep_assertions u_sep_assertions (.clk_sys(clk_sys), .srst(srst), .chip_sel(link.chip_sel),
		.link_clk(link.link_clk), .serial_input(link.serial_input),
		.program_enable_pin(link.program_enable_pin),
		.protect_enable_pin(link.protect_enable_pin), .sout_o(link.sout_o),
		.sout_oe(link.sout_oe), .sout(link.sout));
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		if (fail_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Device ignores starts while busy, so wait it out
	task automatic settle();
		int n;
		for (n = 0; n < 3000 && !(req_ready === 1'b1 && busy === 1'b0); n++)
			@(negedge clk_sys);
	endtask
	task automatic send(input logic [1:0] op, input logic pr, pg, pl,
		input logic [7:0] ad, input logic [15:0] dt, input logic [16:0] n_in);
		int n;
		if (!pl)
			settle();
		@(negedge clk_sys);
		{req_op, req_prot, req_prog, req_poll, req_addr, req_data} = {op, pr, pg, pl, ad, dt};
		req_valid = 1'b1;
		// A poll may wait out a whole frame before it is taken
		for (n = 0; n < 3000 && req_ready !== 1'b1; n++)
			@(negedge clk_sys);
		if (n == 3000)
			chk_val("req taken", 16'h0001, 16'h0000);
		note_q.push_back(n_in);
		@(negedge clk_sys);
		req_valid = 1'b0;
		if (pl)
		begin
			for (n = 0; n < 12 && link.sout_oe !== 1'b1; n++)
				@(negedge clk_sys);
			chk_val("status", 16'(dt[0]), 16'(link.sout));
		end
	endtask
	// Oldest note against each response
	always @(negedge clk_sys)
	begin
		if (rsp_valid === 1'b1)
		begin
			if (note_q.size() == 0)
				chk_val("rsp count", 16'h0001, 16'h0000);
			else
			begin
				nt = note_q.pop_front();
				if (nt[16])
					chk_val("rsp_data", nt[15:0], rsp_data);
			end
		end
	end
	initial
	begin
		#(40_000 * 20);
		fail_count++;
		$display("[ERR] run expected done seen timeout");
		give_verdict();
	end
	initial
	begin
		seed = 31989;
		fail_count = 0;
		num_checks = 0;
		{srst, req_valid, req_op, req_prot, req_prog, req_poll} = 7'h40;
		{req_addr, req_data} = 24'h000000;
		repeat (10) @(negedge clk_sys);
		srst = 1'b0;
		send(OP_MISC, 0, 1, 0, 8'h80, 16'h0000, 17'h0);
		for (i = 0; i < 4; i++)
		begin
			a[i] = {1'b0, 2'(i), 5'($random(seed))};
			d[i] = 16'($random(seed));
			send(OP_WRITE, 0, 1, 0, a[i], d[i], 17'h0);
			if (i == 0)
			begin
				send(OP_READ, 0, 0, 1, 8'h00, 16'h0000, 17'h0);
				settle();
				send(OP_READ, 0, 0, 1, 8'h00, 16'h0001, 17'h0);
			end
		end
		for (i = 0; i < 4; i++)
			send(OP_READ, 0, 0, 0, a[i], 16'h0000, {1'b1, d[i]});
		send(OP_ERASE, 0, 1, 0, a[0], 16'h0000, 17'h0);
		send(OP_READ, 0, 0, 0, a[0], 16'h0000, 17'h1ffff);
		// Writes refused while disabled
		send(OP_MISC, 0, 1, 0, 8'h00, 16'h0000, 17'h0);
		send(OP_WRITE, 0, 1, 0, a[1], ~d[1], 17'h0);
		send(OP_READ, 0, 0, 0, a[1], 16'h0000, {1'b1, d[1]});
		send(OP_MISC, 0, 1, 0, 8'h80, 16'h0000, 17'h0);
		// Pointer protects upper half of the test range
		send(OP_MISC, 1, 1, 0, 8'h40, 16'h0000, 17'h0);
		settle();
		chk_val("protect_ptr", 16'h0040, 16'(protect_ptr));
		send(OP_READ, 1, 0, 0, 8'h00, 16'h0000, 17'h10040);
		send(OP_WRITE, 0, 1, 0, a[3], ~d[3], 17'h0);
		send(OP_WRITE, 0, 1, 0, a[1], ~d[1], 17'h0);
		send(OP_READ, 0, 0, 0, a[3], 16'h0000, {1'b1, d[3]});
		send(OP_READ, 0, 0, 0, a[1], 16'h0000, {1'b1, ~d[1]});
		settle();
		repeat (20) @(negedge clk_sys);
		chk_val("notes left", 16'h0000, 16'(note_q.size()));
		give_verdict();
	end
endmodule

// [rtl/sep_device.sv]
// Purpose: Device end: shifts instructions in, data and status out.
// Assumes: Pins arrive asynchronously and are synchronised to clk_sys.
// Notes: Array is a small register file; pointer is one register.
`timescale 1ns/1ns
// Notes on behaviour
// RQ1 - Input bits captured on link clock rising edge
// RQ2 - Output bits advance on link clock rising edge
// RQ3 - Clock pauses keep shift state intact
// RQ4 - Link clock ignored while deselected
// RQ5 - Edges before start bit change nothing
// RQ6 - Self-timed cycle runs on own timer
// RQ7 - Master gives exact bit count per instruction
// RQ8 - After full count, ignore until new start
// RQ9 - Master deselects between instructions
// RQ10 - Master sends start, opcode, address, data
// RQ11 - Data out only during read instructions
// RQ12 - Status shown after deselect then reselect
// RQ13 - No status if select never toggles
// RQ14 - Otherwise serial output is high impedance
// RQ15 - Master raises program enable for programming
// RQ16 - Master sets protect enable per instruction
// RQ17 - Deselect resets instruction logic
// RQ18 - Master keeps minimum deselect time
// RQ19 - Status low busy, high ready
// RQ20 - Pointer readout: dummy zero then pointer
// RQ21 - Start is first high input bit sampled
module sep_device
	import sep_pkg::*;
#(
	parameter int unsigned PROG_CYC = PROG_CYC_DEFAULT
)
(
	input wire logic clk_sys,
	input wire logic srst,
	sep_link_if.device link,
	output logic busy,
	output logic [PTR_W-1:0] protect_ptr
);
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_SHIFT = 5'h02,
		ST_READ = 5'h04,
		ST_DONE = 5'h08,
		ST_ARMED = 5'h10
	} sep_dev_state_type;

	logic [1:0] cs_s_q, clk_s_q, din_s_q, pe_s_q, pre_s_q;
	logic [OP_W-1:0] op_q, op_d;
	logic clk_prev_q;
	logic cs, sclk, din, pe, pre, rise;
	sep_dev_state_type st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [FRAME_W-1:0] sr_q, sr_d;
	logic [DATA_W-1:0] out_q, out_d;
	logic prot_q, prot_d, pe_lat_q, pe_lat_d;
	logic wen_q, wen_d;
	logic [DATA_W-1:0] mem_q [2**ADDR_W];
	logic [PTR_W-1:0] ptr_q, ptr_d;
	logic [31:0] tmr_q, tmr_d;
	logic [7:0] dsel_q, dsel_d;
	logic stat_q, stat_d, launch;
	logic do_o_q, do_o_d, do_oe_q, do_oe_d;
	logic mem_we;
	logic [ADDR_W-1:0] mem_a;
	logic [DATA_W-1:0] mem_wd;

	// Two-flop synchronisers; only the second stage is read
	always_ff @(posedge clk_sys)
	begin
		cs_s_q <= {cs_s_q[0], link.chip_sel};
		clk_s_q <= {clk_s_q[0], link.link_clk};
		din_s_q <= {din_s_q[0], link.serial_input};
		pe_s_q <= {pe_s_q[0], link.program_enable_pin};
		pre_s_q <= {pre_s_q[0], link.protect_enable_pin};
		clk_prev_q <= srst ? 1'b0 : clk_s_q[1];
	end
	assign cs = cs_s_q[1];
	assign sclk = clk_s_q[1];
	assign din = din_s_q[1];
	assign pe = pe_s_q[1];
	assign pre = pre_s_q[1];
	assign rise = cs && sclk && !clk_prev_q; // RQ1 RQ4

	// Instruction engine, busy timer and output pin
	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		op_d = op_q;
		sr_d = sr_q;
		out_d = out_q;
		prot_d = prot_q;
		pe_lat_d = pe_lat_q;
		wen_d = wen_q;
		ptr_d = ptr_q;
		tmr_d = tmr_q;
		dsel_d = dsel_q;
		stat_d = stat_q;
		do_o_d = do_o_q;
		do_oe_d = 1'b0; // RQ14
		launch = 1'b0;
		mem_we = 1'b0;
		mem_a = sr_q[DATA_W +: ADDR_W];
		mem_wd = sr_q[DATA_W-1:0];
		// Own timer ends the programming cycle
		if (tmr_q != 32'h0)
			tmr_d = tmr_q - 32'h1; // RQ6
		if (!cs)
		begin
			// Deselect clears any partial instruction
			st_d = (st_q == ST_DONE) ? ST_ARMED : ST_IDLE; // RQ17
			cnt_d = '0;
			if (dsel_q != 8'hff)
				dsel_d = dsel_q + 8'h1;
			stat_d = 1'b0;
			// Launch on deselect after any full instruction, read included
			if (st_q == ST_DONE)
				launch = 1'b1;
		end
		else
		begin
			// Status only after a deselect of the least time while busy
			if (dsel_q >= 8'(DESELECT_CYC) && tmr_q != 32'h0)
				stat_d = 1'b1; // RQ12 RQ13
			dsel_d = 8'h0;
			unique case (st_q)
				ST_IDLE, ST_ARMED:
				begin
					if (rise && din && tmr_q == 32'h0)
					begin
						st_d = ST_SHIFT; // RQ21 RQ5
						prot_d = pre;
						pe_lat_d = pe;
					end
				end
				ST_SHIFT:
				begin
					if (rise)
					begin
						sr_d = {sr_q[FRAME_W-2:0], din}; // RQ1 RQ3
						cnt_d = cnt_q + 1'b1;
						// Opcode kept apart, since the data bits push it up the register
						if (cnt_q + 1'b1 == CNT_W'(OP_W))
							op_d = {sr_q[0], din};
						if (cnt_q + 1'b1 == CNT_W'(HDR_W) && sr_q[HDR_W-2 -: OP_W] == OP_READ)
						begin
							st_d = ST_READ; // RQ11
							cnt_d = '0;
							out_d = prot_q ? {1'b0, ptr_q, 7'h0} : mem_q[{sr_q[ADDR_W-2:0], din}];
						end
						else if (cnt_q + 1'b1 == sep_len(op_q, prot_q))
							st_d = ST_DONE; // RQ8
						// Short frames go to the top, where a full frame ends up
						if (cnt_q + 1'b1 == CNT_W'(HDR_W) && st_d != ST_SHIFT)
							sr_d = {sr_q[HDR_W-2:0], din, {DATA_W{1'b0}}};
					end
				end
				ST_READ:
				begin
					do_oe_d = 1'b1; // RQ11
					if (rise)
					begin
						do_o_d = out_q[DATA_W-1]; // RQ2 RQ20
						out_d = {out_q[DATA_W-2:0], 1'b0};
						cnt_d = cnt_q + 1'b1;
						if (cnt_q + 1'b1 == sep_out_len(prot_q))
							st_d = ST_DONE; // RQ8
					end
				end
				ST_DONE:
				begin
					do_oe_d = do_oe_q && (cnt_q != '0);
				end
				default:
					st_d = ST_IDLE;
			endcase
			if (stat_q)
			begin
				do_oe_d = 1'b1;
				do_o_d = (tmr_q == 32'h0); // RQ19
			end
		end
		// Execute a programming instruction once deselected
		if (launch && pe_lat_q)
		begin
			unique case (sr_q[FRAME_W-1 -: OP_W])
				OP_WRITE:
					mem_we = !prot_q && wen_q && (ptr_q == PTR_RESET || mem_a < ptr_q);
				OP_ERASE:
				begin
					mem_we = !prot_q && wen_q && (ptr_q == PTR_RESET || mem_a < ptr_q);
					mem_wd = '1;
				end
				OP_MISC:
				begin
					if (prot_q)
						ptr_d = sr_q[DATA_W +: PTR_W];
					else
						wen_d = sr_q[DATA_W + ADDR_W - 1];
				end
				default:
					mem_we = 1'b0;
			endcase
			if (mem_we)
				tmr_d = PROG_CYC; // RQ6
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			st_q <= ST_IDLE;
			cnt_q <= '0;
			op_q <= '0;
			sr_q <= '0;
			out_q <= '0;
			prot_q <= 1'b0;
			pe_lat_q <= 1'b0;
			wen_q <= 1'b0;
			ptr_q <= PTR_RESET;
			tmr_q <= 32'h0;
			dsel_q <= 8'h0;
			stat_q <= 1'b0;
			do_o_q <= 1'b0;
			do_oe_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			op_q <= op_d;
			sr_q <= sr_d;
			out_q <= out_d;
			prot_q <= prot_d;
			pe_lat_q <= pe_lat_d;
			wen_q <= wen_d;
			ptr_q <= ptr_d;
			tmr_q <= tmr_d;
			dsel_q <= dsel_d;
			stat_q <= stat_d;
			do_o_q <= do_o_d;
			do_oe_q <= do_oe_d;
		end
	end

	// Array store; no reset so it maps to memory
	always_ff @(posedge clk_sys)
	begin
		if (mem_we)
			mem_q[mem_a] <= mem_wd;
	end

	assign link.sout_o = do_o_q;
	assign link.sout_oe = do_oe_q;
	assign busy = (tmr_q != 32'h0);
	assign protect_ptr = ptr_q;
endmodule

// [rtl/sep_link_if.sv]
// Purpose: Pin bundle between master and serial EEPROM device.
// Assumes: Serial output is three-state; pull-up when nobody drives.
// Notes: Wire level is resolved here from the enable.
`timescale 1ns/1ns
interface sep_link_if;
	logic chip_sel;
	logic link_clk;
	logic serial_input;
	logic program_enable_pin;
	logic protect_enable_pin;
	logic sout_o;
	logic sout_oe;
	logic sout;
	// Pull-up resolves the undriven line high
	assign sout = sout_oe ? sout_o : 1'b1;
	modport device (input chip_sel, link_clk, serial_input, program_enable_pin,
		protect_enable_pin, output sout_o, sout_oe);
	modport master (output chip_sel, link_clk, serial_input, program_enable_pin,
		protect_enable_pin, input sout);
endinterface

// [rtl/sep_master.sv]
// Purpose: Master end: sends one instruction per request, reads back.
// Assumes: Link clock made here by a divider from clk_sys.
// Notes: Status poll is a separate request with no clock edges.
`timescale 1ns/1ns
module sep_master
	import sep_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	sep_link_if.master link,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [1:0] req_op,
	input wire logic req_prot,
	input wire logic req_prog,
	input wire logic req_poll,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_data,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_data
);
	typedef enum logic [3:0] {
		MS_IDLE = 4'h1,
		MS_SEND = 4'h2,
		MS_GAP = 4'h4,
		MS_POLL = 4'h8
	} sep_mst_state_type;

	sep_mst_state_type st_q, st_d;
	logic [FRAME_W:0] sr_q, sr_d;
	logic [DATA_W-1:0] rd_q, rd_d;
	logic [CNT_W-1:0] bits_q, bits_d;
	logic [7:0] div_q, div_d;
	logic [1:0] sin_q;
	logic cs_q, cs_d, clk_q, clk_d, pe_q, pe_d, pre_q, pre_d, rv_q, rv_d, rd_en_q, rd_en_d;
	logic fin_q, fin_d;
	// Pin round trip outlasts half a link period; last bit is taken this late
	localparam logic [7:0] LAST_BIT_LAG = 8'h2;

	// Read pin passes two flops before use
	always_ff @(posedge clk_sys)
		sin_q <= {sin_q[0], link.sout};

	// Framing, divider and clock generation
	always_comb
	begin
		st_d = st_q;
		sr_d = sr_q;
		rd_d = rd_q;
		bits_d = bits_q;
		div_d = div_q;
		cs_d = cs_q;
		clk_d = clk_q;
		pe_d = pe_q;
		pre_d = pre_q;
		rv_d = 1'b0;
		rd_en_d = rd_en_q;
		fin_d = fin_q;
		unique case (st_q)
			MS_IDLE:
			begin
				if (req_valid && req_poll)
				begin
					st_d = MS_POLL; // RQ12
					cs_d = 1'b1;
					div_d = 8'h0;
				end
				else if (req_valid)
				begin
					st_d = MS_SEND;
					cs_d = 1'b1;
					sr_d = {1'b1, req_op, req_addr, req_data}; // RQ10
					bits_d = sep_len(req_op, req_prot) + 1'b1; // RQ7
					pe_d = req_prog; // RQ15
					pre_d = req_prot; // RQ16
					rd_en_d = (req_op == OP_READ);
					rd_d = '0;
					div_d = 8'h0;
				end
			end
			MS_SEND:
			begin
				div_d = div_q + 8'h1;
				if (div_q == 8'(LINK_HALF_CYC - 1))
				begin
					div_d = 8'h0;
					clk_d = !clk_q;
					if (clk_q)
					begin
						// Falling edge: next bit out, or end frame
						sr_d = {sr_q[FRAME_W-1:0], 1'b0};
						if (bits_q == '0)
						begin
							st_d = MS_GAP; // RQ9
							cs_d = 1'b0;
							pe_d = 1'b0;
							pre_d = 1'b0;
							fin_d = 1'b1;
						end
					end
					else
					begin
						bits_d = bits_q - 1'b1;
						// Pin shows the bit of the previous rising edge
						if (rd_en_q && bits_q < sep_out_len(pre_q))
							rd_d = {rd_q[DATA_W-2:0], sin_q[1]}; // RQ2
					end
				end
			end
			MS_GAP:
			begin
				div_d = div_q + 8'h1;
				// Last read bit still stands before the device sees deselect
				if (fin_q && div_q == LAST_BIT_LAG)
				begin
					fin_d = 1'b0;
					rv_d = 1'b1;
					if (rd_en_q)
						rd_d = {rd_q[DATA_W-2:0], sin_q[1]}; // RQ2
				end
				if (div_q == 8'(DESELECT_CYC))
					st_d = MS_IDLE; // RQ18
			end
			MS_POLL:
			begin
				div_d = div_q + 8'h1;
				if (div_q == 8'(LINK_HALF_CYC * 2))
				begin
					rd_d = {{(DATA_W-1){1'b0}}, sin_q[1]}; // RQ19
					rv_d = 1'b1;
					cs_d = 1'b0;
					div_d = 8'h0;
					st_d = MS_GAP;
				end
			end
			default:
				st_d = MS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			st_q <= MS_IDLE;
			sr_q <= '0;
			rd_q <= '0;
			bits_q <= '0;
			div_q <= 8'h0;
			cs_q <= 1'b0;
			clk_q <= 1'b0;
			pe_q <= 1'b0;
			pre_q <= 1'b0;
			rv_q <= 1'b0;
			rd_en_q <= 1'b0;
			fin_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			sr_q <= sr_d;
			rd_q <= rd_d;
			bits_q <= bits_d;
			div_q <= div_d;
			cs_q <= cs_d;
			clk_q <= clk_d;
			pe_q <= pe_d;
			pre_q <= pre_d;
			rv_q <= rv_d;
			rd_en_q <= rd_en_d;
			fin_q <= fin_d;
		end
	end

	assign link.chip_sel = cs_q;
	assign link.link_clk = clk_q;
	assign link.serial_input = sr_q[FRAME_W];
	assign link.program_enable_pin = pe_q;
	assign link.protect_enable_pin = pre_q;
	assign req_ready = (st_q == MS_IDLE);
	assign rsp_valid = rv_q;
	assign rsp_data = rd_q;
endmodule

// [rtl/sep_pkg.sv]
// Purpose: Shared constants and types for the serial EEPROM pin link.
// Assumes: 50 MHz system clock on both ends; link clock made by the master.
// Notes: Instruction field layout is a plain generic choice.
package sep_pkg;
	localparam int unsigned SYS_CLK_HZ = 50_000_000;
	localparam int unsigned SYS_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
	// Least deselect time, rounded up to whole cycles
	localparam int unsigned MIN_DESELECT_TIME_NS = 250;
	localparam int unsigned DESELECT_CYC = (MIN_DESELECT_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	// Link clock divider: half period in system cycles
	localparam int unsigned LINK_HALF_CYC = 4;
	// Instruction layout: 2 opcode bits, 8 address bits, 16 data bits
	localparam int unsigned OP_W = 2;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned PTR_W = 8;
	localparam int unsigned HDR_W = OP_W + ADDR_W;
	localparam int unsigned FRAME_W = HDR_W + DATA_W;
	localparam int unsigned CNT_W = 6;
	// Opcodes; protect-enable pin selects the protect group
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_ERASE = 2'h3;
	localparam logic [1:0] OP_MISC = 2'h0;
	// Self-timed cycle length in system cycles
	localparam int unsigned PROG_CYC_DEFAULT = 2000;
	localparam logic [PTR_W-1:0] PTR_RESET = 8'h00;
	// Bit count needed for an instruction after its start bit
	function automatic logic [CNT_W-1:0] sep_len(input logic [1:0] op, input logic prot);
		if (op == OP_WRITE && !prot)
			sep_len = CNT_W'(FRAME_W);
		else if (op == OP_READ)
			sep_len = CNT_W'(HDR_W + (prot ? PTR_W + 1 : DATA_W));
		else
			sep_len = CNT_W'(HDR_W);
	endfunction
	// Number of output bits of a read instruction
	function automatic logic [CNT_W-1:0] sep_out_len(input logic prot);
		sep_out_len = prot ? CNT_W'(PTR_W + 1) : CNT_W'(DATA_W);
	endfunction
endpackage
